// ===== abr_ctrl.sv
// Readout byte mux and sleep/clear sequencing for the converter
`include "abr_consts.svh"
`default_nettype none
module abr_ctrl
    import abr_pkg::*;
#(
    parameter int DOWN_CYC = `ABR_DOWN_CYC,
    parameter int WAKE_CYC = `ABR_WAKE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic sleepClearN,
    input wire logic csN,
    input wire logic rdN,
    input wire logic byteSel,
    input wire logic convDone,
    input wire logic [11:0] convResult,
    output logic [7:0] outputPinsUpper,
    output logic [3:0] outputPinsLower,
    output logic dataOe,
    output logic convAbort,
    output logic resultValid,
    output logic inPowerdown,
    output logic readyOut
);
    localparam int ABORT_CYC = `ABR_ABORT_CYC;
    localparam logic [15:0] DOWN_LIM = 16'(DOWN_CYC - 1);
    localparam logic [15:0] WAKE_LIM = 16'(WAKE_CYC - 1);

    typedef struct packed {
        abr_state_t st;
        logic [15:0] cnt;
        logic [2:0] discard;
        logic [11:0] word;
        logic [7:0] upper;
        logic [3:0] lower;
        logic valid;
    } abr_ctrl_t;

    abr_ctrl_t r_ff;
    abr_ctrl_t nxt_r;
    logic [3:0] pinsSync;
    logic sClr;
    logic csS;
    logic rdS;
    logic bS;
    logic [11:0] shown;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    abr_sync #(
        .W(4),
        .RST_VAL(`ABR_PIN_RST_VAL)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clkEn(clkEn),
        .pinIn({sleepClearN, csN, rdN, byteSel}),
        .pinOut(pinsSync)
    );

    assign sClr = pinsSync[`ABR_PIN_SLEEP];
    assign csS = pinsSync[`ABR_PIN_CS];
    assign rdS = pinsSync[`ABR_PIN_RD];
    assign bS = pinsSync[`ABR_PIN_BYTE];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_r = r_ff;
        shown = r_ff.word;
        case (r_ff.st)
            ST_RUN: begin
                if (!sClr) begin
                    nxt_r.st = ST_RESET;
                    nxt_r.cnt = 16'h0000;
                    nxt_r.valid = 1'b0;
                end
            end
            ST_RESET: begin
                if (sClr) begin
                    nxt_r.st = ST_RUN;
                    nxt_r.discard = `ABR_DISCARD_NUM;
                end else if (r_ff.cnt >= DOWN_LIM) begin
                    nxt_r.st = ST_DOWN;
                    nxt_r.cnt = 16'h0000;
                end else begin
                    nxt_r.cnt = r_ff.cnt + 16'h0001;
                end
            end
            ST_DOWN: begin
                if (sClr) begin
                    nxt_r.st = ST_WAKE;
                    nxt_r.cnt = 16'h0000;
                end
            end
            ST_WAKE: begin
                if (!sClr) begin
                    nxt_r.st = ST_RESET;
                    nxt_r.cnt = 16'h0000;
                end else if (r_ff.cnt >= WAKE_LIM) begin
                    nxt_r.st = ST_RUN;
                    nxt_r.discard = `ABR_DISCARD_NUM;
                end else begin
                    nxt_r.cnt = r_ff.cnt + 16'h0001;
                end
            end
            default: begin
                nxt_r.st = ST_RESET;
                nxt_r.cnt = 16'h0000;
            end
        endcase
        if (convDone && r_ff.st == ST_RUN && sClr && sleepClearN) begin
            nxt_r.word = convResult;
            if (r_ff.discard != 3'h0) begin
                nxt_r.discard = r_ff.discard - 3'h1;
                nxt_r.valid = 1'b0;
            end else begin
                nxt_r.valid = 1'b1;
            end
        end
        if (r_ff.st != ST_RUN) begin
            shown = `ABR_CODE_RESET;
        end
        // Mux follows byte select each cycle that clkEn is high
        if (bS) begin
            nxt_r.upper = {shown[3:0], 4'h0};
            nxt_r.lower = 4'h0;
        end else begin
            nxt_r.upper = shown[11:4];
            nxt_r.lower = shown[3:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_ff.st <= ST_RUN;
            r_ff.cnt <= 16'h0000;
            r_ff.discard <= `ABR_DISCARD_NUM;
            r_ff.word <= 12'h000;
            r_ff.upper <= 8'h00;
            r_ff.lower <= 4'h0;
            r_ff.valid <= 1'b0;
        end else if (clkEn) begin
            r_ff <= nxt_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign outputPinsUpper = r_ff.upper;
    assign outputPinsLower = r_ff.lower;
    // Drive only with select and strobe low
    assign dataOe = !csS && !rdS;
    // Raw pin aborts with no clock
    assign convAbort = !sleepClearN || (r_ff.st != ST_RUN);
    assign resultValid = r_ff.valid;
    assign inPowerdown = (r_ff.st == ST_DOWN);
    assign readyOut = (r_ff.st == ST_RUN);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence seqResetHeld;
        clkEn && r_ff.st == ST_RESET && !sClr && r_ff.cnt == DOWN_LIM;
    endsequence

    sequence seqWakeDone;
        clkEn && r_ff.st == ST_WAKE && sClr && r_ff.cnt == WAKE_LIM;
    endsequence

    a_abort_async: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        !sleepClearN |-> convAbort)
        else $error("abort not raised by low sleep input");

    a_abort_fast: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        $fell(sleepClearN) |-> ##[0:ABORT_CYC] convAbort)
        else $error("abort late after sleep input fell");

    a_reset_code: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && r_ff.st != ST_RUN && !bS) |=>
        ({outputPinsUpper, outputPinsLower} == `ABR_CODE_RESET))
        else $error("reset marker code missing");

    a_byte_low: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && r_ff.st == ST_RUN && !bS) |=>
        (outputPinsUpper == $past(r_ff.word[11:4]) &&
        outputPinsLower == $past(r_ff.word[3:0])))
        else $error("full word readout wrong");

    a_byte_high: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && r_ff.st == ST_RUN && bS) |=>
        (outputPinsUpper == {$past(r_ff.word[3:0]), 4'h0} &&
        outputPinsLower == 4'h0))
        else $error("byte mode readout wrong");

    a_resume_now: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && r_ff.st == ST_RESET && sClr) |=>
        (readyOut && r_ff.discard == `ABR_DISCARD_NUM))
        else $error("no immediate resume after short reset");

    a_enter_down: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        seqResetHeld |=> inPowerdown)
        else $error("powerdown not entered after long low");

    a_reset_first: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && readyOut && !sClr) |=> (r_ff.st == ST_RESET))
        else $error("reset phase skipped");

    a_wake_delay: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        seqWakeDone |=> readyOut)
        else $error("wake delay end not honoured");

    a_wake_early: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && r_ff.st == ST_WAKE && r_ff.cnt < WAKE_LIM) |=>
        !readyOut)
        else $error("ready before wake delay");

    a_discard_four: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && convDone && readyOut && sClr && sleepClearN &&
        r_ff.discard != 3'h0) |=> !resultValid)
        else $error("early result marked valid");

    a_oe_gate: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (csS || rdS) |-> !dataOe)
        else $error("data driven without select and strobe");

    a_straight_bin: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (clkEn && convDone && readyOut && sClr && sleepClearN) |=>
        (r_ff.word == $past(convResult)))
        else $error("result not kept as straight binary");
endmodule : abr_ctrl
`default_nettype wire

// ===== abr_consts.svh
// Constants for the converter readout and sleep/clear controller
`ifndef ABR_CONSTS_SVH
`define ABR_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define ABR_CLK_NS 20
`define ABR_ABORT_NS 45
`define ABR_ABORT_CYC (`ABR_ABORT_NS / `ABR_CLK_NS)
`define ABR_DOWN_NS 20000
`define ABR_DOWN_CYC ((`ABR_DOWN_NS + `ABR_CLK_NS - 1) / `ABR_CLK_NS)
`define ABR_WAKE_NS 1000
`define ABR_WAKE_CYC ((`ABR_WAKE_NS + `ABR_CLK_NS - 1) / `ABR_CLK_NS)

// ----------------------------------------------------------------
// Codes and field positions
// ----------------------------------------------------------------
`define ABR_CODE_RESET 12'hFE0
`define ABR_DISCARD_NUM 3'h4
`define ABR_PIN_SLEEP 3
`define ABR_PIN_CS 2
`define ABR_PIN_RD 1
`define ABR_PIN_BYTE 0
`define ABR_PIN_RST_VAL 4'hE

`endif

// ===== abr_pkg.sv
// Types for the converter readout and sleep/clear controller
`default_nettype none
package abr_pkg;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_RESET,
        ST_DOWN,
        ST_WAKE
    } abr_state_t;
endpackage : abr_pkg
`default_nettype wire

// ===== abr_sync.sv
// Three-stage input synchroniser with agreement filter
`default_nettype none
module abr_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } abr_sync_t;

    abr_sync_t r_ff;
    abr_sync_t nxt_r;
    logic [W-1:0] nxtStable;

    // ----------------------------------------------------------------
    // Per-bit agreement filter
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign nxtStable[i] = (r_ff.s2[i] == r_ff.s3[i]) ?
                r_ff.s3[i] : r_ff.stable[i];
        end
    endgenerate

    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = pinIn;
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        nxt_r.stable = nxtStable;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else if (clkEn) begin
            r_ff <= nxt_r;
        end
    end

    assign pinOut = r_ff.stable;
endmodule : abr_sync
`default_nettype wire

// ===== abr_host_model.sv
// Host model reading the converter over the parallel bus
`default_nettype none
module abr_host_model (
    input wire logic sys_clk,
    output logic csN,
    output logic rdN,
    output logic byteSel,
    output logic sleepClearN,
    input wire logic [7:0] outputPinsUpper,
    input wire logic [3:0] outputPinsLower,
    input wire logic dataOe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        csN = 1'b1;
        rdN = 1'b1;
        byteSel = 1'b0;
        sleepClearN = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic setBus(input logic c, input logic r, input logic b);
        @(posedge sys_clk);
        csN <= c;
        rdN <= r;
        byteSel <= b;
    endtask : setBus
    task automatic setSleep(input logic v);
        @(posedge sys_clk);
        sleepClearN <= v;
    endtask : setSleep
    // byte low then high, strobe toggled or held
    task automatic readPair(input bit hold, output logic [7:0] b0,
                            output logic [7:0] b1, output logic [3:0] l0,
                            output logic [3:0] l1);
        setBus(1'b0, 1'b0, 1'b0);
        tick(7);
        b0 = dataOe ? outputPinsUpper : 8'hXX;
        l0 = dataOe ? outputPinsLower : 4'hX;
        if (!hold) begin
            setBus(1'b0, 1'b1, 1'b0);
            tick(6);
        end
        setBus(1'b0, 1'b0, 1'b1);
        tick(7);
        b1 = dataOe ? outputPinsUpper : 8'hXX;
        l1 = dataOe ? outputPinsLower : 4'hX;
        setBus(1'b1, 1'b1, 1'b0);
        tick(6);
    endtask : readPair
endmodule : abr_host_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the readout and sleep/clear controller
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_b;
    logic clkEn;
    logic convDone;
    logic [11:0] convResult;
    logic sleepClearN, csN, rdN, byteSel;
    logic [7:0] outputPinsUpper;
    logic [3:0] outputPinsLower;
    logic dataOe, convAbort, resultValid, inPowerdown, readyOut;
    int miscompares = 0;
    int checked = 0;
    logic [11:0] vals [6] = '{12'h000, 12'h800, 12'hFFF, 12'h7FF,
                              12'hA5C, 12'h5A3};
    always #10 sys_clk = ~sys_clk;
    abr_ctrl #(.DOWN_CYC(40), .WAKE_CYC(4)) dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn),
        .sleepClearN(sleepClearN), .csN(csN), .rdN(rdN),
        .byteSel(byteSel), .convDone(convDone), .convResult(convResult),
        .outputPinsUpper(outputPinsUpper),
        .outputPinsLower(outputPinsLower), .dataOe(dataOe),
        .convAbort(convAbort), .resultValid(resultValid),
        .inPowerdown(inPowerdown), .readyOut(readyOut));
    abr_host_model hostU (
        .sys_clk(sys_clk), .csN(csN), .rdN(rdN), .byteSel(byteSel),
        .sleepClearN(sleepClearN), .outputPinsUpper(outputPinsUpper),
        .outputPinsLower(outputPinsLower), .dataOe(dataOe));
    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string name, input logic [11:0] seen,
                         input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic waitSig(input int sel, input logic val, input int lim,
                           input string name);
        int n;
        logic s;
        n = 0;
        forever begin
            hostU.tick(1);
            case (sel)
                0: s = readyOut;
                1: s = inPowerdown;
                default: s = dataOe;
            endcase
            if (s === val || n >= lim) break;
            n++;
        end
        check(name, {11'h0, s}, {11'h0, val});
    endtask : waitSig
    task automatic convCheck(input logic [11:0] v, input logic expValid,
                             input bit hold);
        logic [7:0] b0, b1;
        logic [3:0] l0, l1;
        @(posedge sys_clk);
        convDone <= 1'b1;
        convResult <= v;
        @(posedge sys_clk);
        convDone <= 1'b0;
        hostU.tick(1);
        check("resultValid", {11'h0, resultValid}, {11'h0, expValid});
        hostU.readPair(hold, b0, b1, l0, l1);
        check("upperWord", {4'h0, b0}, {4'h0, v[11:4]});
        check("lowerWord", {8'h0, l0}, {8'h0, v[3:0]});
        check("upperByte", {4'h0, b1}, {4'h0, v[3:0], 4'h0});
        check("lowerByte", {8'h0, l1}, 12'h000);
    endtask : convCheck
    task automatic series;
        for (int i = 0; i < 6; i++) begin
            convCheck(vals[i], (i >= 4), i[0]);
        end
    endtask : series
    task automatic busOffCheck;
        hostU.setBus(1'b0, 1'b0, 1'b0);
        waitSig(2, 1'b1, 8, "oeBothLow");
        hostU.setBus(1'b1, 1'b0, 1'b0);
        waitSig(2, 1'b0, 8, "oeCsHigh");
        hostU.setBus(1'b0, 1'b0, 1'b0);
        waitSig(2, 1'b1, 8, "oeBothAgain");
        hostU.setBus(1'b0, 1'b1, 1'b0);
        waitSig(2, 1'b0, 8, "oeRdHigh");
        hostU.setBus(1'b1, 1'b1, 1'b0);
        waitSig(2, 1'b0, 8, "oeIdle");
    endtask : busOffCheck
    task automatic shortReset;
        hostU.setBus(1'b0, 1'b0, 1'b0);
        hostU.tick(7);
        check("abortRun", {11'h0, convAbort}, 12'h000);
        hostU.setSleep(1'b0);
        #1;
        check("abortNow", {11'h0, convAbort}, 12'h001);
        waitSig(0, 1'b0, 8, "resetEntry");
        check("clearValid", {11'h0, resultValid}, 12'h000);
        hostU.tick(6);
        check("markHigh", {4'h0, outputPinsUpper}, 12'h0FE);
        check("markLow", {8'h0, outputPinsLower}, 12'h000);
        check("notDown", {11'h0, inPowerdown}, 12'h000);
        hostU.setBus(1'b0, 1'b0, 1'b1);
        hostU.tick(7);
        check("markByte", {4'h0, outputPinsUpper}, 12'h000);
        hostU.setSleep(1'b1);
        waitSig(0, 1'b1, 8, "resume");
        hostU.setBus(1'b1, 1'b1, 1'b0);
        series();
    endtask : shortReset
    task automatic longReset;
        hostU.setSleep(1'b0);
        hostU.tick(20);
        check("earlyDown", {11'h0, inPowerdown}, 12'h000);
        waitSig(1, 1'b1, 40, "powerdown");
        check("downReady", {11'h0, readyOut}, 12'h000);
        hostU.setSleep(1'b1);
        waitSig(1, 1'b0, 8, "wakeStart");
        check("wakeEarly", {11'h0, readyOut}, 12'h000);
        hostU.tick(3);
        check("wakeHold", {11'h0, readyOut}, 12'h000);
        hostU.tick(1);
        check("wakeDone", {11'h0, readyOut}, 12'h001);
        check("wakeDown", {11'h0, inPowerdown}, 12'h000);
        series();
    endtask : longReset
    task automatic freezeCheck;
        @(posedge sys_clk);
        clkEn <= 1'b0;
        hostU.setSleep(1'b0);
        hostU.tick(10);
        check("frozenAbort", {11'h0, convAbort}, 12'h001);
        check("frozenRun", {11'h0, readyOut}, 12'h001);
        hostU.setSleep(1'b1);
        hostU.tick(2);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        hostU.tick(8);
        check("thawRun", {11'h0, readyOut}, 12'h001);
        check("thawAbort", {11'h0, convAbort}, 12'h000);
    endtask : freezeCheck
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        rst_b <= 1'b0;
        clkEn <= 1'b1;
        convDone <= 1'b0;
        convResult <= 12'h000;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        hostU.tick(8);
        check("powerOnReset", {11'h0, readyOut}, 12'h000);
        hostU.setSleep(1'b1);
        waitSig(0, 1'b1, 8, "powerOnRun");
        series();
        busOffCheck();
        shortReset();
        longReset();
        freezeCheck();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
